// ### rtl/opw_defs.vh
// Offsets, field positions, reset values and timing for the pull word bank
`ifndef OPW_DEFS_VH
`define OPW_DEFS_VH
`define OPW_ADDR_LOW 8'h00
`define OPW_ADDR_HIGH 8'h01
`define OPW_ADDR_RANGE 8'h02
`define OPW_LOW_RESET 16'h0000
`define OPW_HIGH_RESET 16'h0000
`define OPW_HIGH_WORD_MSB 9
`define OPW_OE_BIT 10
`define OPW_HIGH_RO_MSB 15
`define OPW_HIGH_RO_LSB 11
`define OPW_RANGE_MSB 3
`define OPW_WORD_WIDTH 26
`define OPW_DELAY_NS 140000
`define OPW_CLK_PERIOD_NS 10
`define OPW_DELAY_CYCLES (`OPW_DELAY_NS / `OPW_CLK_PERIOD_NS)
`define OPW_APPLY_LATENCY 2
`endif

// ### rtl/opw_apply_stage.v
// Holding stage that applies a new pull word after a latency
`timescale 1ns/10ps
module opw_apply_stage #(
    parameter WIDTH = 26,
    parameter LATENCY = 2
)(
    input wire ref_clk,
    input wire sys_rst,
    input wire load,
    input wire [WIDTH-1:0] load_word,
    output reg [WIDTH-1:0] applied_word,
    output reg change_start
);
    reg [WIDTH-1:0] held_word;
    reg [7:0] count;
    reg busy;
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            held_word <= {WIDTH{1'b0}};
            applied_word <= {WIDTH{1'b0}};
            count <= 8'h00;
            busy <= 1'b0;
            change_start <= 1'b0;
        end
        else
        begin
            change_start <= 1'b0;
            if (load)
            begin
                // Newest word restarts the wait; no partial update reaches out
                held_word <= load_word;
                count <= LATENCY[7:0];
                busy <= 1'b1;
            end
            else if (busy)
            begin
                if (count <= 8'h01)
                begin
                    applied_word <= held_word;
                    change_start <= 1'b1;
                    busy <= 1'b0;
                    count <= 8'h00;
                end
                else
                begin
                    count <= count - 8'h01;
                end
            end
        end
    end
endmodule

// ### rtl/opw_pull_word_regs.v
// Pull word register bank of the steerable oscillator
`timescale 1ns/10ps
`include "opw_defs.vh"
module opw_pull_word_regs #(
    parameter APPLY_LATENCY = `OPW_APPLY_LATENCY
)(
    input wire ref_clk,
    input wire sys_rst,
    input wire oe_pin_mode,
    input wire oe_pin,
    input wire [3:0] pull_range_in,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    output reg reg_rvalid,
    output reg signed [25:0] pull_setting_word,
    output reg [3:0] pull_range,
    output reg change_start,
    output reg output_enable
);
    reg [15:0] lower_pull_word;
    reg [9:0] upper_pull_word;
    reg sw_oe;
    reg high_load;
    reg [25:0] next_word;
    reg low_hit;
    reg high_hit;
    wire [25:0] applied_word;
    wire applied_pulse;
    reg [15:0] next_rdata;

    // Address decode of the write strobe
    always @*
    begin
        low_hit = 1'b0;
        high_hit = 1'b0;
        case (reg_addr)
            `OPW_ADDR_LOW:
            begin
                low_hit = reg_wr;
            end
            `OPW_ADDR_HIGH:
            begin
                high_hit = reg_wr;
            end
            default:
            begin
                // Range and unmapped offsets take no write
                low_hit = 1'b0;
                high_hit = 1'b0;
            end
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            lower_pull_word <= `OPW_LOW_RESET;
        end
        else if (low_hit)
        begin
            // Held only; the oscillator does not move yet
            lower_pull_word <= reg_wdata;
        end
    end

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            upper_pull_word <= 10'h000;
        end
        else if (high_hit)
        begin
            // Bits 15:11 are dropped here, so they always read zero
            upper_pull_word <= reg_wdata[`OPW_HIGH_WORD_MSB:0];
        end
    end

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sw_oe <= 1'b0;
        end
        else if (high_hit && !oe_pin_mode)
        begin
            // Pin-controlled parts keep the bit frozen
            sw_oe <= reg_wdata[`OPW_OE_BIT];
        end
    end

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            high_load <= 1'b0;
            next_word <= 26'h0000000;
        end
        else
        begin
            high_load <= high_hit;
            if (high_hit)
            begin
                // Snapshot with latest low word, applied as one unit
                next_word <= {reg_wdata[`OPW_HIGH_WORD_MSB:0],
                    lower_pull_word};
            end
        end
    end

    // Latency far below the 140 us bound
    opw_apply_stage #(
        .WIDTH(`OPW_WORD_WIDTH),
        .LATENCY(APPLY_LATENCY)
    ) u_apply (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .load(high_load),
        .load_word(next_word),
        .applied_word(applied_word),
        .change_start(applied_pulse)
    );

    always @*
    begin
        next_rdata = 16'h0000;
        case (reg_addr)
            `OPW_ADDR_LOW:
            begin
                next_rdata = lower_pull_word;
            end
            `OPW_ADDR_HIGH:
            begin
                next_rdata = {5'h00, sw_oe, upper_pull_word};
            end
            `OPW_ADDR_RANGE:
            begin
                next_rdata = {12'h000, pull_range_in};
            end
            default:
            begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            // Data holds until the next read, so a slow host is safe
            if (reg_rd)
            begin
                reg_rdata <= next_rdata;
            end
        end
    end

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pull_setting_word <= 26'h0000000;
            change_start <= 1'b0;
        end
        else
        begin
            pull_setting_word <= applied_word;
            change_start <= applied_pulse;
        end
    end

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pull_range <= 4'h0;
        end
        else
        begin
            pull_range <= pull_range_in;
        end
    end

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            output_enable <= 1'b0;
        end
        else if (oe_pin_mode)
        begin
            output_enable <= oe_pin;
        end
        else
        begin
            output_enable <= sw_oe;
        end
    end
endmodule

// ### verification/opw_pull_word_regs_monitor.sv
// Assertion checker for the pull word register bank
`timescale 1ns/10ps
module opw_pull_word_regs_monitor #(parameter APPLY_LATENCY = 2)(
    input logic ref_clk, sys_rst, oe_pin_mode, oe_pin, reg_wr, reg_rd,
    input logic [3:0] pull_range_in, pull_range,
    input logic [7:0] reg_addr,
    input logic [15:0] reg_rdata,
    input logic reg_rvalid, change_start, output_enable,
    input logic signed [25:0] pull_setting_word
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_high_wr;
        reg_wr && reg_addr == 8'h01;
    endsequence
    sequence s_change;
        ##[3:8] change_start;
    endsequence
    a_rd_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("answer without read");
    a_high_ro: assert property (reg_rd && reg_addr == 8'h01 |=> reg_rdata[15:11] == 5'h00)
        else $error("unused bits not zero");
    a_change_bound: assert property (s_high_wr |-> s_change)
        else $error("change late");
    a_change_cause: assert property (change_start |->
        $past(reg_wr && reg_addr == 8'h01, 3 + APPLY_LATENCY))
        else $error("change without high write");
    a_word_hold: assert property (!change_start |->
        $stable(pull_setting_word))
        else $error("word moved without change");
    a_oe_pin: assert property (!$past(sys_rst) && $past(oe_pin_mode) |->
        output_enable == $past(oe_pin))
        else $error("enable not from pin");
    a_range_copy: assert property (!$past(sys_rst) |->
        pull_range == $past(pull_range_in))
        else $error("range copy wrong");
endmodule
bind opw_pull_word_regs opw_pull_word_regs_monitor
    #(.APPLY_LATENCY(APPLY_LATENCY)) i_mon(.*);

// ### verification/opw_host_model.sv
// Host model issuing register writes and reads
`timescale 1ns/10ps
module opw_host_model (
    input logic ref_clk,
    input logic [15:0] reg_rdata,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic [7:0] reg_addr = 8'h00,
    output logic [15:0] reg_wdata = 16'h0000
);
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        // Released data must not look valid
        reg_wdata <= ~d;
    endtask
    task rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask
    // Low word first, so no half-new word is ever applied
    task pull(input logic [15:0] lo, input logic [15:0] hi);
        wr(8'h00, lo);
        wr(8'h01, hi);
    endtask
endmodule

// ### verification/opw_pull_word_regs_tb.sv
// Self-checking bench for the pull word register bank
`timescale 1ns/10ps
module opw_pull_word_regs_tb;
    logic ref_clk = 0, sys_rst = 1, oe_pin_mode = 0, oe_pin = 0;
    logic [3:0] pull_range_in = 4'h0, pull_range;
    logic reg_wr, reg_rd, reg_rvalid, change_start, output_enable;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, v;
    logic signed [25:0] pull_setting_word;
    int err_count = 0, n_checks = 0;
    initial forever #5 ref_clk = ~ref_clk;
    opw_pull_word_regs i_dut(.ref_clk, .sys_rst, .oe_pin_mode, .oe_pin,
        .pull_range_in, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid, .pull_setting_word, .pull_range, .change_start,
        .output_enable);
    opw_host_model i_host(.ref_clk, .reg_rdata, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata);
    task chk(input logic [25:0] got, input logic [25:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim;
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task t_low_only;
        i_host.rd(8'h01, v);
        chk(v, 0);
        chk(output_enable, 0);
        i_host.wr(8'h00, 16'hBEEF);
        i_host.rd(8'h00, v);
        chk(v, 26'hBEEF);
        chk(pull_setting_word, 0);
    endtask
    task t_negative;
        i_host.wr(8'h01, 16'hFFFF);
        repeat (6) @(posedge ref_clk);
        chk(pull_setting_word, 26'h3FFBEEF);
        chk(pull_setting_word < 0, 1);
        chk(output_enable, 1);
        i_host.rd(8'h01, v);
        chk(v, 26'h07FF);
        i_host.pull(16'h1234, 16'h0501);
        repeat (6) @(posedge ref_clk);
        chk(pull_setting_word, 26'h1011234);
    endtask
    task t_pin_mode;
        oe_pin_mode <= 1'b1;
        i_host.wr(8'h01, 16'h0001);
        repeat (2) @(posedge ref_clk);
        chk(output_enable, 0);
        i_host.rd(8'h01, v);
        chk(v, 26'h0401);
        oe_pin_mode <= 1'b0;
    endtask
    task t_range;
        pull_range_in <= 4'hA;
        i_host.rd(8'h02, v);
        chk(v, 26'h000A);
        chk(pull_range, 4'hA);
        i_host.rd(8'h07, v);
        chk(v, 0);
    endtask
    task t_change;
        int n;
        int seen;
        n = 0;
        seen = 0;
        i_host.wr(8'h00, 16'h0042);
        repeat (8)
        begin
            @(posedge ref_clk);
            seen = seen + change_start;
        end
        chk(seen, 0);
        i_host.wr(8'h01, 16'h0000);
        while (change_start !== 1'b1 && n < 20)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk(n, 5);
        chk(pull_setting_word, 26'h0000042);
    endtask
    initial
    begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_low_only;
        t_negative;
        t_pin_mode;
        t_range;
        t_change;
        end_sim;
    end
    initial
    begin
        #20000;
        err_count++;
        end_sim;
    end
endmodule
